// File: rtl/sa_classify_pkg.sv
// package for the security-association field selector and expansion
// flow buffer; shared by the single design module and the bench side
package sa_classify_pkg;

  // encapsulation formats offered per association
  typedef enum logic [2:0] {
    FMT_STANDARD = 3'h0,
    FMT_SINGLE_BYPASS = 3'h1,
    FMT_DUAL_BYPASS = 3'h2,
    FMT_LABEL_BYPASS = 3'h3
  } encap_mode_t;

  // header parse state of the incoming 64-bit word stream
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR = 3'h1,
    ST_BODY = 3'h2
  } parse_state_t;

  // field enable bits inside an association's match mask
  localparam int F_DA = 0;
  localparam int F_SA = 1;
  localparam int F_TPID1 = 2;
  localparam int F_VID1 = 3;
  localparam int F_TPID2 = 4;
  localparam int F_VID2 = 5;
  localparam int F_ETYPE = 6;
  localparam int F_SECTAG = 7;
  localparam int F_LABEL1 = 8;
  localparam int F_LABEL2 = 9;
  localparam int FIELD_COUNT = 10;

  // well-known tag and type values
  localparam logic [15:0] TYPE_CTAG = 16'h8100;
  localparam logic [15:0] TYPE_STAG = 16'h88A8;
  localparam logic [15:0] TYPE_SECTAG = 16'h88E5;
  localparam logic [15:0] TYPE_LABEL = 16'h8847;

  // key length selector values
  localparam logic KEY_128 = 1'b0;
  localparam logic KEY_256 = 1'b1;

  // pause frame constants
  localparam logic [15:0] PAUSE_QUANTA_FULL = 16'hFFFF;
  localparam logic [15:0] PAUSE_QUANTA_ZERO = 16'h0000;
  localparam logic [4:0] RESET_COUNT = 5'h00;

  // bytes left clear ahead of the protected part, per format
  localparam logic [7:0] CLEAR_PLAIN = 8'h0C;
  localparam logic [7:0] CLEAR_ONE_TAG = 8'h10;
  localparam logic [7:0] CLEAR_TWO_TAG = 8'h14;
  localparam logic [7:0] CLEAR_ONE_LABEL = 8'h12;
  localparam logic [7:0] CLEAR_TWO_LABEL = 8'h16;

  // header fields pulled from the start of a frame
  typedef struct packed {
    logic [47:0] dest_addr;
    logic [47:0] src_addr;
    logic [15:0] tag_protocol_identifier1;
    logic [11:0] vlan_identifier1;
    logic [15:0] tag_protocol_identifier2;
    logic [11:0] vlan_identifier2;
    logic [15:0] ether_type;
    logic [63:0] sectag;
    logic [31:0] label1;
    logic [31:0] label2;
  } header_fields_t;

  // one association's configuration
  typedef struct packed {
    logic valid;
    logic egress;
    encap_mode_t mode;
    logic key_len;
    logic [FIELD_COUNT-1:0] field_en;
    header_fields_t value;
  } sa_entry_t;

endpackage : sa_classify_pkg

// File: rtl/sa_classify_formats.sv
// security-association field selection, tag/label bypass offsets and
// expansion flow buffer with pause generation toward the system MAC.
// assumes a 64-bit stream in clk_i domain, frames without preamble/FCS,
// association table driven as static config ports by surrounding logic.
`timescale 1ns/10ps
`default_nettype none
module sa_classify_formats #(
  parameter int SA_COUNT = 16,
  parameter int BUF_DEPTH = 64,
  parameter int PAUSE_ON = 48,
  parameter int PAUSE_OFF = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic in_sof_i,
  input wire logic in_eof_i,
  input wire logic [63:0] in_data_i,
  input wire logic out_ready_i,
  input wire sa_classify_pkg::sa_entry_t sa_table_i [SA_COUNT],
  output logic in_ready_o,
  output logic out_valid_o,
  output logic out_eof_o,
  output logic [63:0] out_data_o,
  output logic match_valid_o,
  output logic match_hit_o,
  output logic [$clog2(SA_COUNT)-1:0] match_index_o,
  output logic match_key_256_o,
  output logic [7:0] protect_offset_o,
  output logic pause_req_o,
  output logic [15:0] pause_quanta_o
);

  localparam int AW = $clog2(BUF_DEPTH);

  // header capture: first four words hold every field needed
  sa_classify_pkg::parse_state_t state;
  sa_classify_pkg::parse_state_t next_state;
  logic [2:0] word_count;
  logic [255:0] hdr;
  logic hdr_done;

  wire take = in_valid_i & in_ready_o;

  always_comb begin
    next_state = state;
    case (state)
      sa_classify_pkg::ST_IDLE:
        if (take && in_sof_i && !in_eof_i) next_state = sa_classify_pkg::ST_HDR;
      sa_classify_pkg::ST_HDR:
        if (take && (in_eof_i || word_count == 3'h3))
          next_state = in_eof_i ? sa_classify_pkg::ST_IDLE
                                : sa_classify_pkg::ST_BODY;
      sa_classify_pkg::ST_BODY:
        if (take && in_eof_i) next_state = sa_classify_pkg::ST_IDLE;
      default: next_state = sa_classify_pkg::ST_IDLE;
    endcase
  end

  // header shift-in; short frames are padded with zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= sa_classify_pkg::ST_IDLE;
      word_count <= 3'h0;
      hdr <= '0;
      hdr_done <= 1'b0;
    end else begin
      state <= next_state;
      hdr_done <= 1'b0;
      if (take && in_sof_i) begin
        hdr <= {in_data_i, 192'h0};
        word_count <= 3'h1;
        hdr_done <= in_eof_i;
      end else if (take && state == sa_classify_pkg::ST_HDR) begin
        hdr[255-64*word_count -: 64] <= in_data_i;
        word_count <= word_count + 3'h1;
        hdr_done <= in_eof_i || word_count == 3'h3;
      end
    end
  end

  // field extraction at fixed byte positions of the wire header
  wire [15:0] t1 = hdr[159:144];
  wire [15:0] t2 = hdr[127:112];
  wire tag1 = (t1 == sa_classify_pkg::TYPE_CTAG) ||
              (t1 == sa_classify_pkg::TYPE_STAG);
  wire tag2 = tag1 && ((t2 == sa_classify_pkg::TYPE_CTAG) ||
                       (t2 == sa_classify_pkg::TYPE_STAG));
  wire lbl = (t1 == sa_classify_pkg::TYPE_LABEL);
  wire lbl2 = lbl && !hdr[120];  // bottom-of-stack clear: second label
  wire [15:0] type_at_t2 = hdr[127:112];
  wire [15:0] type_at_t3 = hdr[95:80];
  sa_classify_pkg::header_fields_t f;
  always_comb begin
    f = '0;
    f.dest_addr = hdr[255:208];
    f.src_addr = hdr[207:160];
    f.tag_protocol_identifier1 = t1;
    f.vlan_identifier1 = hdr[139:128];
    f.tag_protocol_identifier2 = t2;
    f.vlan_identifier2 = hdr[107:96];
    f.ether_type = tag2 ? type_at_t3 : (tag1 ? type_at_t2 : t1);
    f.label1 = hdr[143:112];
    f.label2 = hdr[111:80];
    if (tag2) f.sectag = hdr[95:32];
    else if (tag1) f.sectag = hdr[127:64];
    // one-label carrier: security tag sits right after the label
    else if (lbl) f.sectag = hdr[111:48];
    else f.sectag = hdr[159:96];
  end

  // fields legal for a given direction and format
  function automatic logic [9:0] allowed(
    input logic egress,
    input sa_classify_pkg::encap_mode_t mode,
    input logic has1,
    input logic has2,
    input logic is_lbl,
    input logic is_lbl2
  );
    logic [9:0] a;
    a = '0;
    a[sa_classify_pkg::F_DA] = 1'b1;
    a[sa_classify_pkg::F_SA] = 1'b1;
    if (mode == sa_classify_pkg::FMT_LABEL_BYPASS) begin
      a[sa_classify_pkg::F_ETYPE] = is_lbl;
      a[sa_classify_pkg::F_LABEL1] = is_lbl;
      a[sa_classify_pkg::F_LABEL2] = is_lbl2 & egress;
      a[sa_classify_pkg::F_SECTAG] = !egress & is_lbl & !is_lbl2;
    end else if (egress) begin
      a[sa_classify_pkg::F_TPID1] = has1;
      a[sa_classify_pkg::F_VID1] = has1;
      a[sa_classify_pkg::F_TPID2] = has2;
      a[sa_classify_pkg::F_VID2] = has2;
      a[sa_classify_pkg::F_ETYPE] = 1'b1;
    end else begin
      // standard receive sees only addresses and security tag
      a[sa_classify_pkg::F_SECTAG] = 1'b1;
      // only bypassed tags stay visible: the outer one, plus the inner one for dual bypass
      a[sa_classify_pkg::F_TPID1] = mode != sa_classify_pkg::FMT_STANDARD;
      a[sa_classify_pkg::F_VID1] = mode != sa_classify_pkg::FMT_STANDARD;
      a[sa_classify_pkg::F_TPID2] = mode == sa_classify_pkg::FMT_DUAL_BYPASS;
      a[sa_classify_pkg::F_VID2] = mode == sa_classify_pkg::FMT_DUAL_BYPASS;
    end
    return a;
  endfunction

  // per-field compare of frame against one entry
  function automatic logic [9:0] equal(
    input sa_classify_pkg::header_fields_t x,
    input sa_classify_pkg::header_fields_t y
  );
    logic [9:0] e;
    e = '0;
    e[sa_classify_pkg::F_DA] = x.dest_addr == y.dest_addr;
    e[sa_classify_pkg::F_SA] = x.src_addr == y.src_addr;
    e[sa_classify_pkg::F_TPID1] =
      x.tag_protocol_identifier1 == y.tag_protocol_identifier1;
    e[sa_classify_pkg::F_VID1] = x.vlan_identifier1 == y.vlan_identifier1;
    e[sa_classify_pkg::F_TPID2] =
      x.tag_protocol_identifier2 == y.tag_protocol_identifier2;
    e[sa_classify_pkg::F_VID2] = x.vlan_identifier2 == y.vlan_identifier2;
    e[sa_classify_pkg::F_ETYPE] = x.ether_type == y.ether_type;
    e[sa_classify_pkg::F_SECTAG] = x.sectag == y.sectag;
    e[sa_classify_pkg::F_LABEL1] = x.label1 == y.label1;
    e[sa_classify_pkg::F_LABEL2] = x.label2 == y.label2;
    return e;
  endfunction

  // per-association hit; a field not allowed for the format never matches
  logic [SA_COUNT-1:0] hit;
  for (genvar i = 0; i < SA_COUNT; i++) begin : g_sa
    wire [9:0] en = sa_table_i[i].field_en;
    wire [9:0] ok = allowed(sa_table_i[i].egress, sa_table_i[i].mode,
                            tag1, tag2, lbl, lbl2);
    assign hit[i] = sa_table_i[i].valid && ((en & ~ok) == '0) &&
                    ((equal(f, sa_table_i[i].value) | ~en) == '1);
  end

  // lowest index wins among several hits
  logic [$clog2(SA_COUNT)-1:0] first;
  always_comb begin
    first = '0;
    for (int k = SA_COUNT - 1; k >= 0; k--) begin
      if (hit[k]) first = k[$clog2(SA_COUNT)-1:0];
    end
  end

  // bytes left in clear before protection starts
  wire sa_classify_pkg::encap_mode_t hit_mode = sa_table_i[first].mode;
  logic [7:0] next_offset;
  always_comb begin
    case (hit_mode)
      sa_classify_pkg::FMT_SINGLE_BYPASS:
        next_offset = sa_classify_pkg::CLEAR_ONE_TAG;
      sa_classify_pkg::FMT_DUAL_BYPASS:
        next_offset = tag2 ? sa_classify_pkg::CLEAR_TWO_TAG
                           : sa_classify_pkg::CLEAR_ONE_TAG;
      sa_classify_pkg::FMT_LABEL_BYPASS:
        next_offset = lbl2 ? sa_classify_pkg::CLEAR_TWO_LABEL
                           : sa_classify_pkg::CLEAR_ONE_LABEL;
      default: next_offset = sa_classify_pkg::CLEAR_PLAIN;
    endcase
  end

  // match result registered one cycle after header complete
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      match_valid_o <= 1'b0;
      match_hit_o <= 1'b0;
      match_index_o <= '0;
      match_key_256_o <= 1'b0;
      protect_offset_o <= 8'h00;
    end else begin
      match_valid_o <= hdr_done;
      if (hdr_done) begin
        match_hit_o <= |hit;
        match_index_o <= first;
        match_key_256_o <= (|hit) &&
          (sa_table_i[first].key_len == sa_classify_pkg::KEY_256);
        protect_offset_o <= next_offset;
      end
    end
  end

  // expansion flow buffer
  logic [64:0] mem [BUF_DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] fill;
  wire push = take;
  wire pop = out_valid_o && out_ready_i;
  wire load = (fill != '0) && (!out_valid_o || pop);

  always_ff @(posedge clk_i) begin
    if (push) mem[wptr] <= {in_eof_i, in_data_i};
  end

  // pointers and registered read stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
      out_valid_o <= 1'b0;
      out_eof_o <= 1'b0;
      out_data_o <= 64'h0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (load) rptr <= rptr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        {out_eof_o, out_data_o} <= mem[rptr];
        out_valid_o <= 1'b1;
      end else if (pop) begin
        out_valid_o <= 1'b0;
      end
      // two spare slots cover the one-cycle ready lag
      // ready throttling holds off overflow whether or not the system honours pause
      in_ready_o <= fill < (AW+1)'(BUF_DEPTH - 2);
    end
  end

  // pause with hysteresis from fill level
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pause_req_o <= 1'b0;
      pause_quanta_o <= sa_classify_pkg::PAUSE_QUANTA_ZERO;
    end else begin
      if (!pause_req_o && fill >= (AW+1)'(PAUSE_ON)) begin
        pause_req_o <= 1'b1;
        pause_quanta_o <= sa_classify_pkg::PAUSE_QUANTA_FULL;
      end else if (pause_req_o && fill <= (AW+1)'(PAUSE_OFF)) begin
        pause_req_o <= 1'b0;
        pause_quanta_o <= sa_classify_pkg::PAUSE_QUANTA_ZERO;
      end
    end
  end

endmodule : sa_classify_formats
`default_nettype wire

// File: tb/sa_classify_sva.sv
// port checker for the field selector and expansion flow buffer
// assumes a bind from the bench top and one clock domain
`timescale 1ns/10ps
`default_nettype none
module sa_classify_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_ready_o,
  input wire logic out_ready_i,
  input wire logic out_valid_o,
  input wire logic [63:0] out_data_o,
  input wire logic match_valid_o,
  input wire logic match_hit_o,
  input wire logic [7:0] protect_offset_o,
  input wire logic pause_req_o,
  input wire logic [15:0] pause_quanta_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // quanta is full while pausing, zero otherwise
  property p_quanta;
    pause_quanta_o == (pause_req_o ? 16'hFFFF : 16'h0000);
  endproperty
  a_quanta: assert property (p_quanta) else $error("bad quanta");
  // hysteresis needs 32 drained words before release
  property p_pause_hold;
    $rose(pause_req_o) |-> pause_req_o [*8];
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("short pause");
  // and 32 taken words before a new pause
  property p_pause_gap;
    $fell(pause_req_o) |-> !pause_req_o [*8];
  endproperty
  a_pause_gap: assert property (p_pause_gap) else $error("short gap");
  // pause starts well before the buffer refuses
  property p_pause_early;
    $rose(pause_req_o) |-> in_ready_o;
  endproperty
  a_pause_early: assert property (p_pause_early) else $error("late pause");
  // refusal only while already pausing
  property p_refuse;
    $fell(in_ready_o) |-> pause_req_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refuse no pause");
  // stalled output word stays put
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  // one result pulse per frame
  property p_pulse;
    match_valid_o |=> !match_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  // a hit carries one of the clear-offset figures
  property p_offset;
    match_valid_o && match_hit_o |->
      protect_offset_o inside {8'h0C, 8'h10, 8'h12, 8'h14, 8'h16};
  endproperty
  a_offset: assert property (p_offset) else $error("bad offset");
endmodule : sa_classify_sva
`default_nettype wire

// File: tb/sys_mac_model.sv
// system mac and line sink model for the field selector bench
// assumes one clock; send() words are taken at edges with ready high
`timescale 1ns/10ps
`default_nettype none
module sys_mac_model (
  input wire logic clk_i,
  input wire logic rdy_i,
  input wire logic pause_i,
  input wire logic stall_i,
  output logic valid_o,
  output logic sof_o,
  output logic eof_o,
  output logic [63:0] data_o,
  output logic ready_o
);
  // taken words with their end-of-frame flag on top
  logic [64:0] sent[$];
  initial begin
    valid_o = 1'b0;
    sof_o = 1'b0;
    eof_o = 1'b0;
    data_o = 64'h0;
    ready_o = 1'b1;
  end
  // line sink, stalls only on request
  always @(posedge clk_i) ready_o <= !stall_i;
  // one frame, each word held until taken
  task automatic send(input logic [63:0] w[$]);
    int i;
    @(posedge clk_i);
    // a new frame waits out a pause
    while (pause_i !== 1'b0) @(posedge clk_i);
    for (i = 0; i < w.size(); i++) begin
      valid_o <= 1'b1;
      sof_o <= (i == 0);
      eof_o <= (i == w.size() - 1);
      data_o <= w[i];
      @(posedge clk_i);
      while (rdy_i !== 1'b1) @(posedge clk_i);
      sent.push_back({eof_o, w[i]});
    end
    valid_o <= 1'b0;
    // released bus shows no stale word
    data_o <= ~w[w.size() - 1];
  endtask : send
endmodule : sys_mac_model
`default_nettype wire

// File: tb/tb_top.sv
// bench top: frames through the mac model, results judged here
// assumes checker and model compiled first, default sizes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic stall = 1'b0;
  logic vld, sof, eof, rdy, ordy, ovld, oeof, mv, mh, k256, prq;
  logic [63:0] dat, odat;
  logic [3:0] midx;
  logic [7:0] off;
  logic [15:0] pq;
  sa_classify_pkg::sa_entry_t tbl [16] = '{default: '0};
  sa_classify_pkg::header_fields_t hv;
  logic [63:0] fr[$];
  int failures = 0;
  int compares = 0;
  localparam logic [95:0] ADDR = 96'h0A0B0C0D0E0F_102030405060;
  sa_classify_formats i_sa_classify_formats (.clk_i(clk_i),
    .reset_i(reset_i), .in_valid_i(vld), .in_sof_i(sof), .in_eof_i(eof),
    .in_data_i(dat), .out_ready_i(ordy), .sa_table_i(tbl),
    .in_ready_o(rdy), .out_valid_o(ovld), .out_eof_o(oeof),
    .out_data_o(odat), .match_valid_o(mv), .match_hit_o(mh),
    .match_index_o(midx), .match_key_256_o(k256),
    .protect_offset_o(off), .pause_req_o(prq), .pause_quanta_o(pq));
  sys_mac_model i_sys_mac_model (.clk_i(clk_i), .rdy_i(rdy),
    .pause_i(prq), .stall_i(stall), .valid_o(vld), .sof_o(sof),
    .eof_o(eof), .data_o(dat), .ready_o(ordy));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // empty table, common addresses in the match values
  task automatic clr();
    @(posedge clk_i);
    tbl <= '{default: '0};
    hv = '0;
    hv.dest_addr = ADDR[95:48];
    hv.src_addr = ADDR[47:0];
    @(posedge clk_i);
  endtask : clr
  task automatic cfg(input int i, input logic eg,
    input sa_classify_pkg::encap_mode_t m, input logic k,
    input logic [9:0] en);
    tbl[i] <= {1'b1, eg, m, k, en, hv};
  endtask : cfg
  // eight-word frame, header first; judge the one result
  task automatic run(input logic [255:0] h, input logic [3:0] ix,
    input logic k, input logic [7:0] o);
    int n;
    fr.delete();
    for (n = 0; n < 8; n++) fr.push_back(n < 4 ? h[255-64*n -: 64] : 64'(n));
    n = 0;
    fork
      i_sys_mac_model.send(fr);
      begin
        while (n < 60 && mv !== 1'b1) begin
          @(negedge clk_i);
          n++;
        end
        chk(mv, 1'b1);
        chk(mh, 1'b1);
        chk(midx, ix);
        chk(k256, k);
        chk(off, o);
      end
    join
  endtask : run
  // illegal ethertype field never hits; 256-bit key
  task automatic t_std();
    clr();
    hv.ether_type = 16'h88E5;
    cfg(0, 1'b0, sa_classify_pkg::FMT_STANDARD, 1'b0, 10'h041);
    cfg(1, 1'b0, sa_classify_pkg::FMT_STANDARD, 1'b1, 10'h003);
    run({ADDR, 16'h88E5, 144'h0}, 4'h1, 1'b1, 8'h0C);
  endtask : t_std
  task automatic t_single();
    clr();
    hv.tag_protocol_identifier1 = 16'h8100;
    hv.vlan_identifier1 = 12'h123;
    cfg(0, 1'b0, sa_classify_pkg::FMT_SINGLE_BYPASS, 1'b0, 10'h00D);
    run({ADDR, 48'h8100_0123_88E5, 112'h0}, 4'h0, 1'b0, 8'h10);
  endtask : t_single
  // inner vlan refused, outer tag hits
  task automatic t_dsingle();
    clr();
    hv.tag_protocol_identifier1 = 16'h88A8;
    hv.vlan_identifier1 = 12'h456;
    hv.vlan_identifier2 = 12'h789;
    cfg(0, 1'b0, sa_classify_pkg::FMT_SINGLE_BYPASS, 1'b1, 10'h020);
    cfg(2, 1'b0, sa_classify_pkg::FMT_SINGLE_BYPASS, 1'b1, 10'h00F);
    run({ADDR, 80'h88A8_0456_8100_0789_88E5, 80'h0}, 4'h2, 1'b1,
      8'h10);
  endtask : t_dsingle
  task automatic t_dual();
    clr();
    hv.tag_protocol_identifier2 = 16'h8100;
    hv.vlan_identifier2 = 12'h789;
    hv.ether_type = 16'h0800;
    cfg(3, 1'b1, sa_classify_pkg::FMT_DUAL_BYPASS, 1'b0, 10'h070);
    run({ADDR, 80'h88A8_0456_8100_0789_0800, 80'h0}, 4'h3, 1'b0,
      8'h14);
    // receive side: both tags left clear, security tag next
    clr();
    hv.tag_protocol_identifier2 = 16'h8100;
    hv.vlan_identifier2 = 12'h789;
    hv.sectag = 64'h88E5_2C00_0000_0002;
    cfg(4, 1'b0, sa_classify_pkg::FMT_DUAL_BYPASS, 1'b1, 10'h0B0);
    run({ADDR, 64'h88A8_0456_8100_0789, 64'h88E5_2C00_0000_0002, 32'h0},
      4'h4, 1'b1, 8'h14);
  endtask : t_dual
  task automatic t_label();
    clr();
    hv.ether_type = 16'h8847;
    hv.label1 = 32'h0001_0040;
    hv.label2 = 32'h0002_0140;
    cfg(5, 1'b1, sa_classify_pkg::FMT_LABEL_BYPASS, 1'b1, 10'h343);
    run({ADDR, 80'h8847_0001_0040_0002_0140, 80'h0}, 4'h5, 1'b1,
      8'h16);
    // receive side: one label, security tag right after it
    clr();
    hv.ether_type = 16'h8847;
    hv.label1 = 32'h0001_0140;
    hv.sectag = 64'h88E5_2C00_0000_0001;
    cfg(6, 1'b0, sa_classify_pkg::FMT_LABEL_BYPASS, 1'b0, 10'h1C3);
    run({ADDR, 48'h8847_0001_0140, 64'h88E5_2C00_0000_0001, 48'h0}, 4'h6,
      1'b0, 8'h12);
  endtask : t_label
  // stalled sink fills the buffer, then drains
  task automatic t_flow();
    int n;
    @(posedge clk_i);
    stall <= 1'b1;
    fr.delete();
    for (n = 0; n < 70; n++) fr.push_back({32'hF10F_0000, 32'(n)});
    n = 0;
    fork
      i_sys_mac_model.send(fr);
      begin
        while (n < 300 && rdy !== 1'b0) begin
          @(negedge clk_i);
          n++;
        end
        chk(rdy, 1'b0);
        chk(prq, 1'b1);
        chk(pq, 16'hFFFF);
        @(posedge clk_i);
        stall <= 1'b0;
        n = 0;
        while (n < 300 && prq !== 1'b0) begin
          @(negedge clk_i);
          n++;
        end
        chk(prq, 1'b0);
        chk(pq, 16'h0000);
      end
    join
  endtask : t_flow
  // every output word and its end flag in input order
  always @(posedge clk_i) begin
    if (ovld === 1'b1 && ordy === 1'b1) begin
      chk({oeof, odat}, i_sys_mac_model.sent.pop_front());
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_std();
    t_single();
    t_dsingle();
    t_dual();
    t_label();
    t_flow();
    repeat (100) @(posedge clk_i);
    chk(i_sys_mac_model.sent.size(), 0);
    summarize();
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule : tb_top
bind sa_classify_formats sa_classify_sva i_sa_classify_sva (
  .clk_i(clk_i), .reset_i(reset_i), .in_ready_o(in_ready_o),
  .out_ready_i(out_ready_i), .out_valid_o(out_valid_o),
  .out_data_o(out_data_o), .match_valid_o(match_valid_o),
  .match_hit_o(match_hit_o), .protect_offset_o(protect_offset_o),
  .pause_req_o(pause_req_o), .pause_quanta_o(pause_quanta_o));
`default_nettype wire
